// ### rtl/power_status_pkg.sv
`default_nettype none
package power_status_pkg;
  localparam logic [7:0] DYN_CFG_ADDR     = 8'h77;
  localparam logic [7:0] PWR_CTRL_ADDR    = 8'h78;
  localparam logic [7:0] CH_STS_ADDR      = 8'h79;
  localparam logic [7:0] DEVICE_MODE_STATE_ADDR    = 8'h7A;
  localparam logic [7:0] DYN_CFG_RESET    = 8'h00;
  localparam logic [7:0] PWR_CTRL_RESET   = 8'h00;
  localparam logic [7:0] CH_STS_RESET     = 8'h00;
  localparam logic [7:0] DEVICE_MODE_STATE_RESET   = 8'h80;
  localparam logic [7:0] DYN_CFG_WMASK    = 8'hCA;
  localparam logic [7:0] PWR_CTRL_WMASK   = 8'hAC;
  localparam int DYN_EN_BIT      = 7;
  localparam int DYN_MAXCH_BIT   = 6;
  localparam int SPLIT_CLK_BIT   = 3;
  localparam int SWAP_BIT        = 1;
  localparam int CONV_ON_BIT     = 7;
  localparam int BIAS_ON_BIT     = 5;
  localparam int ULTRA_EN_BIT    = 3;
  localparam int VOICE_EN_BIT    = 2;
  localparam int CH_STS_LSB      = 4;
  localparam int MODE_LSB        = 5;
  localparam int LOOP_STS_BIT    = 4;
  localparam int BIAS_STS_BIT    = 3;
  localparam int BOOST_CONVERTER_STATE_BIT   = 2;
  localparam int IN_FLT_BIT      = 1;
  localparam int BIAS_FLT_BIT    = 0;
  localparam logic [2:0] MODE_SLEEP       = 3'h4;
  localparam logic [2:0] MODE_ACTIVE_IDLE = 3'h6;
  localparam logic [2:0] MODE_ACTIVE_REC  = 3'h7;
endpackage
`default_nettype wire

// ### rtl/record_power_control_status.sv
// Contract
// [RQ1] dynamic power enable lets each channel change power alone while recording runs.
// [RQ2] dynamic max channel select limits dynamic control to channels 1-2 or widens it to 1-4.
// [RQ3] split clock select tells the dynamic logic whether modulator and mic clocks differ.
// [RQ4] the pair exchange bit swaps converter channels 1 and 2.
// [RQ5] converter power off downs all channels; on powers only enabled ones.
// [RQ6] bias power bit powers the bias generator up or down.
// [RQ7] ultrasound detector runs only while its enable bit is set.
// [RQ8] voice detector runs only while its enable bit is set.
// [RQ9] channel status bits 7..4 show power state of channels 1..4.
// [RQ10] mode field reads 4 sleep, 6 active all off, 7 active some on, 4 after reset.
// [RQ11] status bit 4 shows the loop enabled.
// [RQ12] status bit 3 shows the bias enabled.
// [RQ13] status bit 2 shows the boost converter enabled.
// [RQ14] status bit 1 shows some channel downed by input faults.
// [RQ15] status bit 0 shows all channels downed by bias faults.
// [RQ16] software writes reserved bits only as zero.
// [RQ17] writes to status registers change nothing.
`default_nettype none
module record_power_control_status #(
  parameter int CHANNELS = 4
) (
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  input  wire logic [CHANNELS-1:0] channel_enable,
  input  wire logic                recording_active,
  input  wire logic                device_awake,
  input  wire logic                loop_enabled,
  input  wire logic                boost_enabled,
  input  wire logic                input_fault,
  input  wire logic                bias_fault,
  output logic      [CHANNELS-1:0] channel_power_on,
  output logic                     channel_pair_exchange,
  output logic                     dynamic_split_clock_select,
  output logic                     microphone_bias_power_on,
  output logic                     ultrasound_detect_enable,
  output logic                     voice_detect_enable
);

  ////////////////////////////////////////////////////////////////////
  // synchronisers for pins from the analog side

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [5:0] raw_in;
  assign raw_in = {recording_active, device_awake, loop_enabled, boost_enabled, input_fault, bias_fault};

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  logic rec_s;
  logic awake_s;
  logic loop_s;
  logic boost_s;
  logic in_flt_s;
  logic bias_flt_s;
  assign {rec_s, awake_s, loop_s, boost_s, in_flt_s, bias_flt_s} = sync_q;

  logic [CHANNELS-1:0] en_meta_q;
  logic [CHANNELS-1:0] en_s_q;
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      en_meta_q <= '0;
      en_s_q    <= '0;
    end
    else
    begin
      en_meta_q <= channel_enable;
      en_s_q    <= en_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0] dyn_cfg_q;
  logic [7:0] pwr_ctrl_q;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      dyn_cfg_q <= power_status_pkg::DYN_CFG_RESET;
    else if (reg_wr && reg_addr == power_status_pkg::DYN_CFG_ADDR)
      dyn_cfg_q <= reg_wdata & power_status_pkg::DYN_CFG_WMASK; // [RQ16]
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      pwr_ctrl_q <= power_status_pkg::PWR_CTRL_RESET;
    else if (reg_wr && reg_addr == power_status_pkg::PWR_CTRL_ADDR)
      pwr_ctrl_q <= reg_wdata & power_status_pkg::PWR_CTRL_WMASK; // [RQ16]
  end

  logic dyn_en;
  logic dyn_max;
  logic conv_on;
  assign dyn_en  = dyn_cfg_q[power_status_pkg::DYN_EN_BIT];
  assign dyn_max = dyn_cfg_q[power_status_pkg::DYN_MAXCH_BIT];
  assign conv_on = pwr_ctrl_q[power_status_pkg::CONV_ON_BIT];

  ////////////////////////////////////////////////////////////////////
  // channel power decision

  logic [CHANNELS-1:0] power_d;
  logic [CHANNELS-1:0] power_q;
  logic [CHANNELS-1:0] dyn_allowed;

  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
      dyn_allowed[i] = dyn_en && (i < 2 || dyn_max); // [RQ1] [RQ2]
  end

  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (!conv_on || bias_flt_s || in_flt_s)
        power_d[i] = 1'b0; // [RQ5] [RQ14] [RQ15]
      else if (rec_s && !dyn_allowed[i])
        power_d[i] = power_q[i]; // [RQ1]
      else
        power_d[i] = en_s_q[i]; // [RQ5]
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      power_q <= '0;
    else
      power_q <= power_d;
  end

  logic in_flt_q;
  logic bias_flt_q;
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      in_flt_q   <= 1'b0;
      bias_flt_q <= 1'b0;
    end
    else
    begin
      in_flt_q   <= in_flt_s && conv_on && (en_s_q != '0); // [RQ14]
      bias_flt_q <= bias_flt_s && conv_on; // [RQ15]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs toward the analog and detector logic

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      channel_power_on           <= '0;
      channel_pair_exchange      <= 1'b0;
      dynamic_split_clock_select <= 1'b0;
      microphone_bias_power_on   <= 1'b0;
      ultrasound_detect_enable   <= 1'b0;
      voice_detect_enable        <= 1'b0;
    end
    else
    begin
      channel_power_on           <= power_d;
      channel_pair_exchange      <= dyn_cfg_q[power_status_pkg::SWAP_BIT]; // [RQ4]
      dynamic_split_clock_select <= dyn_cfg_q[power_status_pkg::SPLIT_CLK_BIT]; // [RQ3]
      microphone_bias_power_on   <= pwr_ctrl_q[power_status_pkg::BIAS_ON_BIT]; // [RQ6]
      ultrasound_detect_enable   <= pwr_ctrl_q[power_status_pkg::ULTRA_EN_BIT]; // [RQ7]
      voice_detect_enable        <= pwr_ctrl_q[power_status_pkg::VOICE_EN_BIT]; // [RQ8]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status registers, driven only by internal state

  logic [7:0] ch_sts;
  logic [7:0] device_mode_state;
  logic [2:0] mode_code;

  always_comb
  begin
    ch_sts = 8'h00;
    for (int i = 0; i < CHANNELS && i < 4; i++)
      ch_sts[7 - i] = power_q[i]; // [RQ9]
  end

  always_comb
  begin
    if (!awake_s)
      mode_code = power_status_pkg::MODE_SLEEP; // [RQ10]
    else if (power_q != '0)
      mode_code = power_status_pkg::MODE_ACTIVE_REC;
    else
      mode_code = power_status_pkg::MODE_ACTIVE_IDLE;
  end

  always_comb
  begin
    device_mode_state = 8'h00;
    device_mode_state[power_status_pkg::MODE_LSB +: 3]  = mode_code;
    device_mode_state[power_status_pkg::LOOP_STS_BIT]   = loop_s; // [RQ11]
    device_mode_state[power_status_pkg::BIAS_STS_BIT]   = microphone_bias_power_on; // [RQ12]
    device_mode_state[power_status_pkg::BOOST_CONVERTER_STATE_BIT]  = boost_s; // [RQ13]
    device_mode_state[power_status_pkg::IN_FLT_BIT]     = in_flt_q; // [RQ14]
    device_mode_state[power_status_pkg::BIAS_FLT_BIT]   = bias_flt_q; // [RQ15]
  end

  ////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses read zero

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        power_status_pkg::DYN_CFG_ADDR:  reg_rdata <= dyn_cfg_q;
        power_status_pkg::PWR_CTRL_ADDR: reg_rdata <= pwr_ctrl_q;
        power_status_pkg::CH_STS_ADDR:   reg_rdata <= ch_sts; // [RQ17]
        power_status_pkg::DEVICE_MODE_STATE_ADDR: reg_rdata <= device_mode_state; // [RQ17]
        default:                         reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  a_master_off_kills: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ5]
    !conv_on |=> channel_power_on == '0) else $error("channels on with converter off");
  a_enabled_powers: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ5]
    conv_on && !rec_s && !in_flt_s && !bias_flt_s |=> channel_power_on == $past(en_s_q))
    else $error("enabled channel not powered");
  a_static_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ1]
    conv_on && rec_s && !dyn_en && !in_flt_s && !bias_flt_s |=> power_q == $past(power_q))
    else $error("channel changed without dynamic control");
  a_max_limit: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ2]
    conv_on && rec_s && dyn_en && !dyn_max && !in_flt_s && !bias_flt_s
    |=> power_q[CHANNELS-1:2] == $past(power_q[CHANNELS-1:2]))
    else $error("upper channel changed with limit");
  a_swap_follows: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ4]
    ##1 channel_pair_exchange == $past(dyn_cfg_q[power_status_pkg::SWAP_BIT]))
    else $error("swap output wrong");
  a_split_follows: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ3]
    ##1 dynamic_split_clock_select == $past(dyn_cfg_q[power_status_pkg::SPLIT_CLK_BIT]))
    else $error("split clock output wrong");
  a_bias_follows: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ6]
    ##1 microphone_bias_power_on == $past(pwr_ctrl_q[power_status_pkg::BIAS_ON_BIT]))
    else $error("bias output wrong");
  a_ultra_follows: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ7]
    ##1 ultrasound_detect_enable == $past(pwr_ctrl_q[power_status_pkg::ULTRA_EN_BIT]))
    else $error("ultrasound enable wrong");
  a_voice_follows: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ8]
    ##1 voice_detect_enable == $past(pwr_ctrl_q[power_status_pkg::VOICE_EN_BIT]))
    else $error("voice enable wrong");
  a_status_map: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ9]
    reg_rd && reg_addr == power_status_pkg::CH_STS_ADDR
    |=> reg_rdata[7:4] == {$past(power_q[0]), $past(power_q[1]), $past(power_q[2]), $past(power_q[3])})
    else $error("channel status wrong");
  a_mode_code: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ10]
    mode_code == power_status_pkg::MODE_SLEEP || mode_code == power_status_pkg::MODE_ACTIVE_IDLE
    || mode_code == power_status_pkg::MODE_ACTIVE_REC) else $error("reserved mode code");
  a_bias_fault_all: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ15]
    bias_flt_q |-> channel_power_on == '0) else $error("bias fault left channel on");
  a_status_nowrite: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ17]
    reg_wr && (reg_addr == power_status_pkg::CH_STS_ADDR) |=> $stable(dyn_cfg_q) && $stable(pwr_ctrl_q))
    else $error("status write disturbed config");

  // register port steps that the checks below use
  sequence s_dyn_write;
    reg_wr && reg_addr == power_status_pkg::DYN_CFG_ADDR;
  endsequence

  sequence s_pwr_write;
    reg_wr && reg_addr == power_status_pkg::PWR_CTRL_ADDR;
  endsequence

  sequence s_mode_read;
    reg_rd && reg_addr == power_status_pkg::DEVICE_MODE_STATE_ADDR;
  endsequence

  sequence s_status_write;
    reg_wr && (reg_addr == power_status_pkg::CH_STS_ADDR || reg_addr == power_status_pkg::DEVICE_MODE_STATE_ADDR);
  endsequence

  a_swap_from_write: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ4]
    s_dyn_write |=> ##1 channel_pair_exchange == $past(reg_wdata[power_status_pkg::SWAP_BIT], 2))
    else $error("swap not taken from write");
  a_split_from_write: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ3]
    s_dyn_write |=> ##1 dynamic_split_clock_select == $past(reg_wdata[power_status_pkg::SPLIT_CLK_BIT], 2))
    else $error("split clock not taken from write");
  a_bias_from_write: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ6]
    s_pwr_write |=> ##1 microphone_bias_power_on == $past(reg_wdata[power_status_pkg::BIAS_ON_BIT], 2))
    else $error("bias power not taken from write");
  a_ultra_from_write: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ7]
    s_pwr_write |=> ##1 ultrasound_detect_enable == $past(reg_wdata[power_status_pkg::ULTRA_EN_BIT], 2))
    else $error("ultrasound enable not taken from write");
  a_voice_from_write: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ8]
    s_pwr_write |=> ##1 voice_detect_enable == $past(reg_wdata[power_status_pkg::VOICE_EN_BIT], 2))
    else $error("voice enable not taken from write");
  a_conv_off_write: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ5]
    s_pwr_write ##0 !reg_wdata[power_status_pkg::CONV_ON_BIT] |=> ##1 channel_power_on == '0)
    else $error("channels on after converter off write");
  a_mode_bias_read: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ12]
    s_mode_read |=> reg_rdata[power_status_pkg::BIAS_STS_BIT] == $past(microphone_bias_power_on))
    else $error("bias status read wrong");
  a_mode_sleep_read: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ10]
    s_mode_read ##0 !awake_s |=> reg_rdata[power_status_pkg::MODE_LSB +: 3] == power_status_pkg::MODE_SLEEP)
    else $error("sleep code not read");
  a_mode_idle_read: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ10]
    s_mode_read ##0 (awake_s && power_q == '0)
    |=> reg_rdata[power_status_pkg::MODE_LSB +: 3] == power_status_pkg::MODE_ACTIVE_IDLE)
    else $error("idle code not read");
  a_mode_rec_read: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ10]
    s_mode_read ##0 (awake_s && power_q != '0)
    |=> reg_rdata[power_status_pkg::MODE_LSB +: 3] == power_status_pkg::MODE_ACTIVE_REC)
    else $error("recording code not read");
  a_reset_sleep: assert property (@(posedge sys_clk) // [RQ10]
    !resetn |=> mode_code == power_status_pkg::MODE_SLEEP && channel_power_on == '0)
    else $error("not asleep after reset");
  a_mode_nowrite: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ17]
    s_status_write |=> $stable(dyn_cfg_q) && $stable(pwr_ctrl_q))
    else $error("status write disturbed config");
  a_in_fault_off: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ14]
    in_flt_q |-> channel_power_on == '0)
    else $error("input fault left channel on");
  a_dyn_full: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ2]
    conv_on && rec_s && dyn_en && dyn_max && !in_flt_s && !bias_flt_s |=> power_q == $past(en_s_q))
    else $error("wide dynamic control not followed");
  a_dyn_lower: assert property (@(posedge sys_clk) disable iff (!resetn) // [RQ1]
    conv_on && rec_s && dyn_en && !in_flt_s && !bias_flt_s |=> power_q[1:0] == $past(en_s_q[1:0]))
    else $error("dynamic control not followed");

endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk, resetn, reg_wr, reg_rd, recording_active, device_awake;
  logic       loop_enabled, boost_enabled, input_fault, bias_fault, rd_seen;
  logic       swap_o, split_o, bias_o, ultra_o, voice_o;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, w;
  logic [3:0] channel_enable, channel_power_on;
  logic [7:0] exp_q[$];
  int         err_count, checks;
  record_power_control_status #(.CHANNELS(4)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .channel_enable(channel_enable), .recording_active(recording_active),
    .device_awake(device_awake), .loop_enabled(loop_enabled),
    .boost_enabled(boost_enabled), .input_fault(input_fault), .bias_fault(bias_fault),
    .channel_power_on(channel_power_on), .channel_pair_exchange(swap_o),
    .dynamic_split_clock_select(split_o), .microphone_bias_power_on(bias_o),
    .ultrasound_detect_enable(ultra_o), .voice_detect_enable(voice_o)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected=%h seen=%h", name, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = wr;
    reg_rd = ~wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic settle;
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  function automatic logic [7:0] outs();
    return {3'h0, swap_o, split_o, bias_o, ultra_o, voice_o};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // read data settles on the read edge and is checked at the next negedge
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk)
    if (rd_seen === 1'b1 && exp_q.size() > 0)
      check("reg_rdata", reg_rdata, exp_q.pop_front());
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    {reg_wr, reg_rd, recording_active, device_awake} = 4'h0;
    {loop_enabled, boost_enabled, input_fault, bias_fault} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    channel_enable = 4'h0;
    void'($urandom(32'hC503));
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    rd(8'h77, 8'h00);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h00);
    rd(8'h7A, 8'h80);
    done("reset");
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($urandom()) & 8'hCA;
      w = 8'($urandom()) & 8'hAC;
      acc(1'b1, 8'h77, v);
      acc(1'b1, 8'h78, w);
      rd(8'h77, v & 8'hCA);
      rd(8'h78, w & 8'hAC);
      settle();
      check("cfg_out", outs(), {3'h0, v[1], v[3], w[5], w[3], w[2]});
    end
    done("config");
    acc(1'b1, 8'h79, 8'hF0);
    acc(1'b1, 8'h7A, 8'h7F);
    acc(1'b1, 8'h10, 8'hFF);
    rd(8'h79, 8'h00);
    rd(8'h7A, 8'h80 | {4'h0, w[5], 3'h0});
    rd(8'h10, 8'h00);
    done("status_write");
    acc(1'b1, 8'h77, 8'h00);
    channel_enable = 4'b1011;
    device_awake = 1'b1;
    loop_enabled = 1'b1;
    boost_enabled = 1'b1;
    acc(1'b1, 8'h78, 8'hA0);
    settle();
    check("ch_power", {4'h0, channel_power_on}, 8'h0B);
    rd(8'h79, 8'hD0);
    rd(8'h7A, 8'hFC);
    acc(1'b1, 8'h78, 8'h00);
    settle();
    check("ch_power", {4'h0, channel_power_on}, 8'h00);
    rd(8'h7A, 8'hD4);
    done("power");
    boost_enabled = 1'b0;
    acc(1'b1, 8'h78, 8'h80);
    input_fault = 1'b1;
    settle();
    check("ch_power", {4'h0, channel_power_on}, 8'h00);
    rd(8'h7A, 8'hD2);
    input_fault = 1'b0;
    bias_fault = 1'b1;
    settle();
    check("ch_power", {4'h0, channel_power_on}, 8'h00);
    rd(8'h7A, 8'hD1);
    bias_fault = 1'b0;
    done("faults");
    channel_enable = 4'b0011;
    settle();
    recording_active = 1'b1;
    channel_enable = 4'b0111;
    settle();
    check("ch_power", {4'h0, channel_power_on}, 8'h03);
    acc(1'b1, 8'h77, 8'h80);
    channel_enable = 4'b0110;
    settle();
    check("ch_power", {4'h0, channel_power_on}, 8'h02);
    acc(1'b1, 8'h77, 8'hC0);
    settle();
    check("ch_power", {4'h0, channel_power_on}, 8'h06);
    rd(8'h79, 8'h60);
    settle();
    done("dynamic");
    summarize();
  end
endmodule
`default_nettype wire
